// ==== core/pmt_pkg.sv ====
// Shared constants and types of the program memory table read block.
`default_nettype none
package pmt_pkg;
   localparam int PM_AW = 11;
   localparam int PM_DW = 16;
   localparam logic [PM_AW-1:0] RESET_VECTOR = 11'h000;
   localparam logic [2:0] LAST_PAGE_BITS = 3'h7;
   localparam int PTR_HI_BITS = 3;
   localparam int CLKS_PER_INSTR = 4;
   localparam int TABLE_INSTR_CYCLES = 2;
   localparam int TABLE_CLKS = CLKS_PER_INSTR * TABLE_INSTR_CYCLES;
   localparam int EE_WORDS_DEF = 64;
   localparam int HDR_BITS = 13;
   localparam int DATA_BITS = 16;
   localparam int HDR_TARGET_POS = 12;
   localparam int HDR_WRITE_POS = 11;
   typedef enum logic [1:0] {SP_HDR, SP_WDATA, SP_RDATA} pmt_sp_state_t;
endpackage : pmt_pkg
`default_nettype wire

// ==== core/pmt_prog_if.sv ====
// Carrier between the serial programming port and the memory core.
`timescale 1ns/100ps
`default_nettype none
interface pmt_prog_if;
   logic mode_on;
   logic req;
   logic is_ee;
   logic is_wr;
   logic [10:0] addr;
   logic [15:0] wdata;
   logic [15:0] rdata;
   modport port (output mode_on, req, is_ee, is_wr, addr, wdata, input rdata);
   modport mem (input mode_on, req, is_ee, is_wr, addr, wdata, output rdata);
endinterface : pmt_prog_if
`default_nettype wire

// ==== core/pmt_serial_port.sv ====
// Two-wire serial programming and debug port, sampled on the system clock.
`timescale 1ns/100ps
`default_nettype none
module pmt_serial_port (
   input wire logic clk,
   input wire logic reset,
   input wire logic prog_enable,
   input wire logic sdata_i,
   output logic sdata_o,
   output logic sdata_oe_n,
   input wire logic sclk,
   pmt_prog_if.port prog
);
   import pmt_pkg::*;
   logic ck_s1_r, ck_s2_r, ck_s3_r, da_s1_r, da_s2_r, en_s1_r, en_s2_r;
   pmt_sp_state_t st_r, st_nxt;
   logic [4:0] cnt_r, cnt_nxt;
   logic [HDR_BITS-1:0] hdr_r, hdr_nxt;
   logic [DATA_BITS-1:0] dat_r, dat_nxt;
   logic req_r, req_nxt, out_r, out_nxt, oe_n_r, oe_n_nxt;
   logic rise, fall;

   assign rise = ck_s2_r & ~ck_s3_r;
   assign fall = ~ck_s2_r & ck_s3_r;

   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      hdr_nxt = hdr_r;
      dat_nxt = dat_r;
      req_nxt = 1'b0;
      out_nxt = out_r;
      oe_n_nxt = oe_n_r;
      if (!en_s2_r) begin
         st_nxt = SP_HDR;
         cnt_nxt = 5'h00;
         oe_n_nxt = 1'b1;
      end else begin
         unique case (st_r)
            SP_HDR: if (rise) begin
               hdr_nxt = {hdr_r[HDR_BITS-2:0], da_s2_r};
               cnt_nxt = cnt_r + 5'h01;
               if (cnt_r == 5'(HDR_BITS - 1)) begin
                  cnt_nxt = 5'h00;
                  if (hdr_r[HDR_WRITE_POS-1]) begin
                     st_nxt = SP_WDATA;
                  end else begin
                     req_nxt = 1'b1;
                     st_nxt = SP_RDATA;
                  end
               end
            end
            SP_WDATA: if (rise) begin
               dat_nxt = {dat_r[DATA_BITS-2:0], da_s2_r};
               cnt_nxt = cnt_r + 5'h01;
               if (cnt_r == 5'(DATA_BITS - 1)) begin
                  cnt_nxt = 5'h00;
                  req_nxt = 1'b1;
                  st_nxt = SP_HDR;
               end
            end
            SP_RDATA: if (fall) begin
               // The pin turns round to drive read data on the falling clock edges.
               cnt_nxt = cnt_r + 5'h01;
               if (cnt_r == 5'h00) begin
                  dat_nxt = {prog.rdata[DATA_BITS-2:0], 1'b0};
                  out_nxt = prog.rdata[DATA_BITS-1];
                  oe_n_nxt = 1'b0;
               end else if (cnt_r == 5'(DATA_BITS)) begin
                  oe_n_nxt = 1'b1;
                  cnt_nxt = 5'h00;
                  st_nxt = SP_HDR;
               end else begin
                  out_nxt = dat_r[DATA_BITS-1];
                  dat_nxt = {dat_r[DATA_BITS-2:0], 1'b0};
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      ck_s1_r <= sclk;
      ck_s2_r <= ck_s1_r;
      da_s1_r <= sdata_i;
      da_s2_r <= da_s1_r;
      if (reset) begin
         ck_s3_r <= 1'b0;
         en_s1_r <= 1'b0;
         en_s2_r <= 1'b0;
         st_r <= SP_HDR;
         cnt_r <= 5'h00;
         hdr_r <= '0;
         dat_r <= '0;
         req_r <= 1'b0;
         out_r <= 1'b0;
         oe_n_r <= 1'b1;
      end else begin
         ck_s3_r <= ck_s2_r;
         en_s1_r <= prog_enable;
         en_s2_r <= en_s1_r;
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         hdr_r <= hdr_nxt;
         dat_r <= dat_nxt;
         req_r <= req_nxt;
         out_r <= out_nxt;
         oe_n_r <= oe_n_nxt;
      end
   end

   assign prog.mode_on = en_s2_r;
   assign prog.req = req_r;
   assign prog.is_ee = hdr_r[HDR_TARGET_POS];
   assign prog.is_wr = hdr_r[HDR_WRITE_POS];
   assign prog.addr = hdr_r[PM_AW-1:0];
   assign prog.wdata = dat_r;
   assign sdata_o = out_r;
   assign sdata_oe_n = oe_n_r;

   chk_pin_drive_read : assert property (@(posedge clk) disable iff (reset)
      !oe_n_r |-> st_r == SP_RDATA) else $error("Data pin driven outside a read frame.");
endmodule : pmt_serial_port
`default_nettype wire

// ==== core/pmt_table_read.sv ====
// Program memory with reset vector, table read path and serial programming access.
`timescale 1ns/100ps
`default_nettype none
module pmt_table_read #(
   parameter int EE_WORDS = pmt_pkg::EE_WORDS_DEF,
   parameter int LATCH_BITS = 8,
   parameter bit EMU_VARIANT = 1'b0
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic pc_step,
   input wire logic pc_load,
   input wire logic [pmt_pkg::PM_AW-1:0] pc_load_addr,
   output logic [pmt_pkg::PM_AW-1:0] pc_o,
   output logic [pmt_pkg::PM_DW-1:0] instr_o,
   input wire logic tbl_rd_req,
   input wire logic read_table_last_page,
   input wire logic [7:0] tbl_rd_dest,
   input wire logic ptr_lo_we,
   input wire logic ptr_hi_we,
   input wire logic latch_we,
   input wire logic [7:0] ptr_wdata,
   output logic [7:0] ptr_lo_o,
   output logic [7:0] ptr_hi_o,
   output logic [7:0] table_high_byte_latch,
   output logic tbl_busy,
   output logic wb_valid,
   output logic [7:0] wb_dest,
   output logic [7:0] wb_data,
   input wire logic prog_enable,
   input wire logic program_serial_data_pin_i,
   output logic program_serial_data_pin_o,
   output logic program_serial_data_pin_oe_n,
   input wire logic program_serial_clock_pin,
   output logic pin_func_en
);
   import pmt_pkg::*;

   localparam int EE_AW = $clog2(EE_WORDS);

   // The EEPROM index is a plain bit slice, so only power-of-two depths are served.
   if (LATCH_BITS < 1 || LATCH_BITS > 8) begin : g_bad_latch_bits
      $error("LATCH_BITS must be 1 to 8.");
   end
   if (EE_WORDS < 2 || EE_WORDS > 2048 || 2**EE_AW != EE_WORDS) begin : g_bad_ee_words
      $error("EE_WORDS must be a power of two from 2 to 2048.");
   end

   pmt_prog_if prog ();

   // The same two pins serve in-circuit programming and on-chip debug.
   pmt_serial_port u_port (
      .clk(clk),
      .reset(reset),
      .prog_enable(prog_enable),
      .sdata_i(program_serial_data_pin_i),
      .sdata_o(program_serial_data_pin_o),
      .sdata_oe_n(program_serial_data_pin_oe_n),
      .sclk(program_serial_clock_pin),
      .prog(prog.port)
   );

   logic [PM_DW-1:0] pm_mem [2**PM_AW];
   logic [7:0] ee_mem [EE_WORDS];
   logic [PM_DW-1:0] prog_rd_r;

   logic [PM_AW-1:0] pc_r, pc_nxt;
   logic [PM_DW-1:0] instr_r;
   logic [7:0] ptr_lo_r, ptr_lo_nxt, ptr_hi_r, ptr_hi_nxt, latch_r, latch_nxt;
   logic [PM_AW-1:0] tbl_addr_r, tbl_addr_nxt;
   logic [PM_DW-1:0] rd_word_r;
   logic busy_r, busy_nxt, wbv_r, wbv_nxt;
   logic [3:0] cnt_r, cnt_nxt;
   logic [7:0] dest_r, dest_nxt, wbd_r, wbd_nxt, wbdest_r, wbdest_nxt;
   logic pfe_r, pfe_nxt;
   logic accept;
   logic [7:0] latch_mask;

   assign accept = tbl_rd_req & ~busy_r;
   assign latch_mask = 8'((9'h001 << LATCH_BITS) - 9'h001);

   always_comb begin
      pc_nxt = pc_r;
      if (pc_load) begin
         pc_nxt = pc_load_addr;
      end else if (pc_step) begin
         pc_nxt = pc_r + 11'h001;
      end
      ptr_lo_nxt = ptr_lo_we ? ptr_wdata : ptr_lo_r;
      ptr_hi_nxt = ptr_hi_we ? {5'h00, ptr_wdata[PTR_HI_BITS-1:0]} : ptr_hi_r;
      tbl_addr_nxt = tbl_addr_r;
      busy_nxt = busy_r;
      cnt_nxt = cnt_r;
      dest_nxt = dest_r;
      wbv_nxt = 1'b0;
      wbd_nxt = wbd_r;
      wbdest_nxt = wbdest_r;
      latch_nxt = latch_r;
      if (accept) begin
         if (read_table_last_page) begin
            tbl_addr_nxt = {LAST_PAGE_BITS, ptr_lo_r};
         end else begin
            tbl_addr_nxt = {ptr_hi_r[PTR_HI_BITS-1:0], ptr_lo_r};
         end
         busy_nxt = 1'b1;
         cnt_nxt = 4'(TABLE_CLKS - 1);
         dest_nxt = tbl_rd_dest;
      end else if (busy_r) begin
         cnt_nxt = cnt_r - 4'h1;
         if (cnt_r == 4'h0) begin
            busy_nxt = 1'b0;
            wbv_nxt = 1'b1;
            wbd_nxt = rd_word_r[7:0];
            wbdest_nxt = dest_r;
            latch_nxt = rd_word_r[15:8] & latch_mask;
         end
      end
      pfe_nxt = ~EMU_VARIANT & ~prog.mode_on;
   end

   always_ff @(posedge clk) begin
      instr_r <= pm_mem[pc_r];
      rd_word_r <= pm_mem[tbl_addr_r];
      if (reset) begin
         pc_r <= RESET_VECTOR;
         ptr_lo_r <= 8'h00;
         ptr_hi_r <= 8'h00;
         latch_r <= 8'h00;
         tbl_addr_r <= '0;
         busy_r <= 1'b0;
         cnt_r <= 4'h0;
         dest_r <= 8'h00;
         wbv_r <= 1'b0;
         wbd_r <= 8'h00;
         wbdest_r <= 8'h00;
         pfe_r <= 1'b0;
      end else begin
         pc_r <= pc_nxt;
         ptr_lo_r <= ptr_lo_nxt;
         ptr_hi_r <= ptr_hi_nxt;
         latch_r <= latch_nxt;
         tbl_addr_r <= tbl_addr_nxt;
         busy_r <= busy_nxt;
         cnt_r <= cnt_nxt;
         dest_r <= dest_nxt;
         wbv_r <= wbv_nxt;
         wbd_r <= wbd_nxt;
         wbdest_r <= wbdest_nxt;
         pfe_r <= pfe_nxt;
      end
   end

   // Serial access to flash and EEPROM; EEPROM words read back in the low byte.
   always_ff @(posedge clk) begin
      if (prog.req && prog.is_wr) begin
         if (prog.is_ee) begin
            ee_mem[prog.addr[EE_AW-1:0]] <= prog.wdata[7:0];
         end else begin
            pm_mem[prog.addr] <= prog.wdata;
         end
      end
      if (prog.is_ee) begin
         prog_rd_r <= {8'h00, ee_mem[prog.addr[EE_AW-1:0]]};
      end else begin
         prog_rd_r <= pm_mem[prog.addr];
      end
   end

   assign prog.rdata = prog_rd_r;

   assign pc_o = pc_r;
   assign instr_o = instr_r;
   assign ptr_lo_o = ptr_lo_r;
   assign ptr_hi_o = ptr_hi_r;
   assign table_high_byte_latch = latch_r;
   assign tbl_busy = busy_r;
   assign wb_valid = wbv_r;
   assign wb_dest = wbdest_r;
   assign wb_data = wbd_r;
   assign pin_func_en = pfe_r;

   chk_reset_pc_zero : assert property (@(posedge clk)
      reset ##1 (!reset && !pc_load && !pc_step) |-> pc_r == RESET_VECTOR)
      else $error("Program counter not at reset vector after reset.");
   chk_paged_address : assert property (@(posedge clk) disable iff (reset)
      accept && !read_table_last_page |=>
      tbl_addr_r == {$past(ptr_hi_r[2:0]), $past(ptr_lo_r)})
      else $error("Paged table address wrongly formed.");
   chk_last_page_addr : assert property (@(posedge clk) disable iff (reset)
      accept && read_table_last_page |=> tbl_addr_r == {3'h7, $past(ptr_lo_r)})
      else $error("Last-page table address wrongly formed.");
   chk_low_byte_dest : assert property (@(posedge clk) disable iff (reset)
      accept ##8 1'b1 |=> wbv_r && wbd_r == $past(rd_word_r[7:0]) && wbdest_r == $past(dest_r))
      else $error("Table low byte or destination wrong.");
   chk_high_byte_latch : assert property (@(posedge clk) disable iff (reset)
      wbv_r |-> latch_r == ($past(rd_word_r[15:8]) & latch_mask))
      else $error("Table-high latch holds wrong value.");
   chk_latch_readonly : assert property (@(posedge clk) disable iff (reset)
      ##1 !wbv_r |-> $stable(latch_r))
      else $error("Table-high latch changed without a table read.");
   chk_latch_wr_ignored : assert property (@(posedge clk) disable iff (reset)
      latch_we && !(busy_r && cnt_r == 4'h0) |=> $stable(latch_r))
      else $error("Software write changed the table-high latch.");
   chk_two_cycle_read : assert property (@(posedge clk) disable iff (reset)
      accept |=> (busy_r && !wbv_r) [*8] ##1 (!busy_r && wbv_r))
      else $error("Table read did not take exactly two instruction cycles.");
   chk_ee_write : assert property (@(posedge clk) disable iff (reset)
      prog.req && prog.is_wr && prog.is_ee |=>
      ee_mem[$past(prog.addr[EE_AW-1:0])] == $past(prog.wdata[7:0]))
      else $error("EEPROM serial write lost.");
   chk_emu_pins_off : assert property (@(posedge clk) disable iff (reset)
      EMU_VARIANT || prog.mode_on |=> !pfe_r)
      else $error("Shared pin function active in emulation or programming.");
   chk_ptr_retain : assert property (@(posedge clk) disable iff (reset)
      busy_r && !ptr_lo_we && !ptr_hi_we |=> $stable(ptr_lo_r) && $stable(ptr_hi_r))
      else $error("Table pointer changed by a table read.");
endmodule : pmt_table_read
`default_nettype wire

// ==== tb/pmt_prog_tool.sv ====
// Behavioural model of the external programming and debug tool.
`timescale 1ns/100ps
`default_nettype none
module pmt_prog_tool (
   input wire logic dev_o,
   input wire logic dev_oe_n,
   output logic pin_level,
   output logic sclk
);
   logic drv_d;
   logic oe_bad;
   // The shared data line carries whichever side is driving it.
   assign pin_level = dev_oe_n ? drv_d : dev_o;
   initial begin
      drv_d = 1'b0;
      sclk = 1'b0;
      oe_bad = 1'b0;
   end
   task automatic clk_bit(input logic b);
      drv_d = b;
      sclk = 1'b0;
      #32;
      sclk = 1'b1;
      #32;
   endtask : clk_bit
   task automatic frame(input logic ee, input logic wr, input logic [10:0] a,
      input logic [15:0] wd, output logic [15:0] rd);
      logic [12:0] hdr;
      hdr = {ee, wr, a};
      rd = 16'h0000;
      for (int i = 12; i >= 0; i--) begin
         clk_bit(hdr[i]);
      end
      if (wr) begin
         for (int i = 15; i >= 0; i--) begin
            clk_bit(wd[i]);
         end
      end else begin
         // Released by the tool, the line shows the inverse of its last level.
         drv_d = ~drv_d;
         for (int i = 15; i >= 0; i--) begin
            sclk = 1'b0;
            #32;
            oe_bad = oe_bad | (dev_oe_n !== 1'b0);
            rd[i] = pin_level;
            sclk = 1'b1;
            #32;
         end
      end
      // The clock stands still low between frames.
      sclk = 1'b0;
      #64;
   endtask : frame
endmodule : pmt_prog_tool
`default_nettype wire

// ==== tb/pmt_table_read_bench.sv ====
// Self-checking bench of the program memory table read block.
`timescale 1ns/100ps
`default_nettype none
module pmt_table_read_bench;
   logic clk, reset, pc_step, pc_load, tbl_rd_req, read_table_last_page;
   logic ptr_lo_we, ptr_hi_we, latch_we, prog_enable, tbl_busy, wb_valid;
   logic program_serial_data_pin_i, program_serial_data_pin_o;
   logic program_serial_data_pin_oe_n, program_serial_clock_pin, pin_func_en;
   logic emu_func_en;
   logic [10:0] pc_load_addr, pc_o;
   logic [15:0] instr_o, rd;
   logic [7:0] tbl_rd_dest, ptr_wdata, ptr_lo_o, ptr_hi_o, table_high_byte_latch;
   logic [7:0] wb_dest, wb_data, emu_latch;
   int mismatches = 0;
   int check_count = 0;
   pmt_table_read dut (.clk, .reset, .pc_step, .pc_load, .pc_load_addr, .pc_o,
      .instr_o, .tbl_rd_req, .read_table_last_page, .tbl_rd_dest, .ptr_lo_we,
      .ptr_hi_we, .latch_we, .ptr_wdata, .ptr_lo_o, .ptr_hi_o,
      .table_high_byte_latch, .tbl_busy, .wb_valid, .wb_dest, .wb_data,
      .prog_enable, .program_serial_data_pin_i, .program_serial_data_pin_o,
      .program_serial_data_pin_oe_n, .program_serial_clock_pin, .pin_func_en);
   pmt_table_read #(.LATCH_BITS(5), .EMU_VARIANT(1'b1)) dut_emu (.clk, .reset,
      .pc_step, .pc_load, .pc_load_addr, .pc_o(), .instr_o(), .tbl_rd_req,
      .read_table_last_page, .tbl_rd_dest, .ptr_lo_we, .ptr_hi_we, .latch_we,
      .ptr_wdata, .ptr_lo_o(), .ptr_hi_o(), .table_high_byte_latch(emu_latch),
      .tbl_busy(), .wb_valid(), .wb_dest(), .wb_data(), .prog_enable,
      .program_serial_data_pin_i, .program_serial_data_pin_o(),
      .program_serial_data_pin_oe_n(), .program_serial_clock_pin,
      .pin_func_en(emu_func_en));
   pmt_prog_tool tool (.dev_o(program_serial_data_pin_o),
      .dev_oe_n(program_serial_data_pin_oe_n), .pin_level(program_serial_data_pin_i),
      .sclk(program_serial_clock_pin));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic close_out;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : close_out
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic ptr_write(input logic hi, input logic [7:0] d);
      ptr_hi_we = hi;
      ptr_lo_we = ~hi;
      ptr_wdata = d;
      @(posedge clk);
      #1 ptr_hi_we = 1'b0;
      ptr_lo_we = 1'b0;
      @(posedge clk);
      #1;
   endtask : ptr_write
   task automatic tbl_read(input logic last, input logic [7:0] dest,
      input logic [15:0] word, input logic poke);
      int n;
      n = 0;
      tbl_rd_req = 1'b1;
      read_table_last_page = last;
      tbl_rd_dest = dest;
      @(posedge clk);
      #1;
      // A refused request and a latch write land in the middle of the read.
      while (tbl_busy === 1'b1 && n < 20) begin
         tbl_rd_req = poke && n == 2;
         latch_we = poke && n == 2;
         tbl_rd_dest = (poke && n == 2) ? ~dest : dest;
         @(posedge clk);
         #1 n++;
      end
      if (n == 0) tbl_rd_req = 1'b0;
      chk(16'(n), 16'h0008);
      chk({15'h0000, wb_valid}, 16'h0001);
      chk({8'h00, wb_dest}, {8'h00, dest});
      chk({8'h00, wb_data}, {8'h00, word[7:0]});
      chk({8'h00, table_high_byte_latch}, {8'h00, word[15:8]});
      chk({8'h00, emu_latch}, {11'h000, word[12:8]});
   endtask : tbl_read
   task automatic t_reset;
      chk({5'h00, pc_o}, 16'h0000);
      chk({ptr_lo_o, ptr_hi_o}, 16'h0000);
      chk({table_high_byte_latch, 6'h00, tbl_busy, wb_valid}, 16'h0000);
      chk({14'h0000, program_serial_data_pin_oe_n, pin_func_en}, 16'h0003);
      chk({15'h0000, emu_func_en}, 16'h0000);
      $display("reset test done");
   endtask : t_reset
   task automatic t_serial;
      prog_enable = 1'b1;
      repeat (8) @(posedge clk);
      #1 chk({14'h0000, pin_func_en, emu_func_en}, 16'h0000);
      tool.frame(1'b0, 1'b1, 11'h706, 16'h001A, rd);
      tool.frame(1'b0, 1'b1, 11'h7FF, 16'hA55A, rd);
      tool.frame(1'b0, 1'b1, 11'h106, 16'h3C0F, rd);
      tool.frame(1'b0, 1'b1, 11'h000, 16'h1234, rd);
      tool.frame(1'b1, 1'b1, 11'h005, 16'hBE34, rd);
      tool.frame(1'b0, 1'b0, 11'h7FF, 16'h0000, rd);
      chk(rd, 16'hA55A);
      tool.frame(1'b1, 1'b0, 11'h005, 16'h0000, rd);
      chk(rd, 16'h0034);
      chk({15'h0000, tool.oe_bad}, 16'h0000);
      chk({15'h0000, program_serial_data_pin_oe_n}, 16'h0001);
      @(posedge clk);
      #1 prog_enable = 1'b0;
      repeat (8) @(posedge clk);
      #1 chk({14'h0000, pin_func_en, emu_func_en}, 16'h0002);
      $display("serial test done");
   endtask : t_serial
   task automatic t_table;
      ptr_write(1'b0, 8'h06);
      ptr_write(1'b1, 8'hF9);
      chk({ptr_lo_o, ptr_hi_o}, 16'h0601);
      tbl_read(1'b0, 8'h21, 16'h3C0F, 1'b1);
      tbl_read(1'b1, 8'h42, 16'h001A, 1'b0);
      chk({ptr_lo_o, ptr_hi_o}, 16'h0601);
      ptr_write(1'b0, 8'hFF);
      tbl_read(1'b1, 8'h7F, 16'hA55A, 1'b0);
      // A software write to the latch while idle must leave it alone.
      latch_we = 1'b1;
      ptr_wdata = 8'h3C;
      @(posedge clk);
      #1 latch_we = 1'b0;
      @(posedge clk);
      #1 chk({8'h00, table_high_byte_latch}, 16'h00A5);
      chk({8'h00, emu_latch}, 16'h0005);
      $display("table test done");
   endtask : t_table
   task automatic t_vector;
      pc_load = 1'b1;
      pc_load_addr = 11'h7FF;
      @(posedge clk);
      #1 pc_load = 1'b0;
      pc_step = 1'b1;
      chk({5'h00, pc_o}, 16'h07FF);
      @(posedge clk);
      #1 pc_step = 1'b0;
      chk(instr_o, 16'hA55A);
      reset = 1'b1;
      repeat (2) @(posedge clk);
      #1 reset = 1'b0;
      @(posedge clk);
      #1 chk({5'h00, pc_o}, 16'h0000);
      chk(instr_o, 16'h1234);
      $display("vector test done");
   endtask : t_vector
   initial begin
      {reset, pc_step, pc_load, tbl_rd_req, read_table_last_page} = 5'h10;
      {ptr_lo_we, ptr_hi_we, latch_we, prog_enable} = 4'h0;
      pc_load_addr = 11'h000;
      tbl_rd_dest = 8'h00;
      ptr_wdata = 8'h00;
      repeat (2) @(posedge clk);
      #1 reset = 1'b0;
      @(posedge clk);
      #1 t_reset();
      t_serial();
      t_table();
      t_vector();
      close_out();
   end
   initial begin
      #100000;
      mismatches++;
      close_out();
   end
endmodule : pmt_table_read_bench
`default_nettype wire
